// file: src/bsdes_decryptor.sv
// Bitstream decryptor: link capture, key store, chained multi-pass decryption
`timescale 1ns/1ps
module bsdes_decryptor (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_lclk,
  input wire logic i_cfg_valid,
  input wire bsdes_pkg::bsdes_word_s i_cfg_word,
  output logic o_cfg_ready,
  input wire logic i_scan_key_mode,
  input wire logic i_scan_key_wr,
  input wire logic [2:0] i_scan_key_addr,
  input wire bsdes_pkg::bsdes_key_s i_scan_key_data,
  input wire logic i_config_clear_pin_n,
  input wire logic i_scan_startup_instruction,
  input wire logic i_core_power_good,
  input wire logic i_key_backup_supply,
  input wire logic i_auxiliary_supply,
  output logic o_out_valid,
  output logic [63:0] o_out_data,
  output logic o_keys_loaded,
  output logic o_key_mode,
  output logic o_locked,
  output logic o_cfg_error,
  output logic o_config_done,
  output logic o_mem_clear
);
  typedef enum logic [1:0] {ST_IDLE, ST_PASS} bsdes_state_e;
  localparam int PIN_W = 7;

  // Link side: one word in flight, ready falls until the core acknowledges it
  bsdes_pkg::bsdes_word_s lk_hold_reg;
  logic lk_req_reg;
  logic lk_ack_s1;
  logic lk_ack_s2;
  logic ack_reg;

  always_ff @(posedge i_lclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      lk_ack_s1 <= 1'b0;
      lk_ack_s2 <= 1'b0;
    end
    else
    begin
      lk_ack_s1 <= ack_reg;
      lk_ack_s2 <= lk_ack_s1;
    end
  end

  always_ff @(posedge i_lclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      lk_hold_reg <= '0;
      lk_req_reg <= 1'b0;
      o_cfg_ready <= 1'b1;
    end
    else if (i_cfg_valid && o_cfg_ready)
    begin
      lk_hold_reg <= i_cfg_word;
      lk_req_reg <= ~lk_req_reg;
      o_cfg_ready <= 1'b0;
    end
    else if (lk_ack_s2 == lk_req_reg)
      o_cfg_ready <= 1'b1;
  end

  // Core side synchronisers; the third stage only feeds edge detection
  logic [2:0] req_sync;
  logic [PIN_W-1:0] pin_s1;
  logic [PIN_W-1:0] pin_s2;
  logic [PIN_W-1:0] pin_s3;
  logic [66:0] kd_s1;
  logic [66:0] kd_s2;
  logic word_evt;

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      req_sync <= 3'h0;
      pin_s1 <= 7'h78;
      pin_s2 <= 7'h78;
      pin_s3 <= 7'h78;
      kd_s1 <= '0;
      kd_s2 <= '0;
    end
    else
    begin
      req_sync <= {req_sync[1:0], lk_req_reg};
      pin_s1 <= {i_auxiliary_supply, i_key_backup_supply, i_core_power_good,
                 i_config_clear_pin_n, i_scan_startup_instruction, i_scan_key_wr,
                 i_scan_key_mode};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      kd_s1 <= {i_scan_key_addr, i_scan_key_data};
      kd_s2 <= kd_s1;
    end
  end

  logic key_mode;
  logic mode_rise;
  logic mode_fall;
  logic wr_rise;
  logic clear_evt;
  logic supply_lost;
  logic [2:0] kaddr;
  assign word_evt = req_sync[2] ^ req_sync[1];
  assign key_mode = pin_s2[0];
  assign mode_rise = pin_s2[0] & ~pin_s3[0];
  assign mode_fall = ~pin_s2[0] & pin_s3[0];
  assign wr_rise = pin_s2[1] & ~pin_s3[1];
  assign clear_evt = (pin_s2[2] & ~pin_s3[2]) | (~pin_s2[3] & pin_s3[3]) |
                     (~pin_s2[4] & pin_s3[4]);
  assign supply_lost = ~pin_s2[5] & ~pin_s2[6];
  assign kaddr = kd_s2[66:64];

  // Key store; i_rstn stands for the key domain's own power-on reset
  bsdes_pkg::bsdes_key_s [bsdes_pkg::BSDES_NUM_KEYS-1:0] key_reg;
  logic [bsdes_pkg::BSDES_NUM_KEYS-1:0] written_reg;

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      key_reg <= {bsdes_pkg::BSDES_NUM_KEYS{bsdes_pkg::BSDES_KEY_RST}};
      written_reg <= '0;
      o_keys_loaded <= 1'b0;
    end
    else if (mode_rise || supply_lost)
    begin
      key_reg <= {bsdes_pkg::BSDES_NUM_KEYS{bsdes_pkg::BSDES_KEY_RST}};
      written_reg <= '0;
      o_keys_loaded <= 1'b0;
    end
    else if (key_mode && wr_rise && kaddr < 3'(bsdes_pkg::BSDES_NUM_KEYS) &&
             !written_reg[kaddr])
    begin
      key_reg[kaddr] <= kd_s2[63:0];
      written_reg[kaddr] <= 1'b1;
    end
    else if (mode_fall)
      o_keys_loaded <= &written_reg;
  end

  // Tag walk from the chosen start location
  function automatic bsdes_pkg::bsdes_tag_e tag_of(input bsdes_pkg::bsdes_key_s k);
    tag_of = bsdes_pkg::bsdes_tag_e'(k.hdr[bsdes_pkg::BSDES_TAG_LSB +: 2]);
  endfunction

  bsdes_pkg::bsdes_word_s wd_reg;
  logic [2:0] hdr_start;
  logic [2:0] hdr_last;
  logic chain_ok;
  bsdes_pkg::bsdes_tag_e t0;
  bsdes_pkg::bsdes_tag_e t1;
  bsdes_pkg::bsdes_tag_e t2;

  always_comb
  begin
    hdr_start = wd_reg.data[bsdes_pkg::BSDES_HDR_START_BIT] ? bsdes_pkg::BSDES_START_HI :
                bsdes_pkg::BSDES_START_LO;
    t0 = tag_of(key_reg[hdr_start]);
    t1 = tag_of(key_reg[hdr_start + 3'h1]);
    t2 = tag_of(key_reg[hdr_start + 3'h2]);
    chain_ok = (t0 == bsdes_pkg::BSDES_TAG_S) || ((t0 == bsdes_pkg::BSDES_TAG_F) &&
               ((t1 == bsdes_pkg::BSDES_TAG_L) ||
                (t1 == bsdes_pkg::BSDES_TAG_M && t2 == bsdes_pkg::BSDES_TAG_L)));
    if (t0 == bsdes_pkg::BSDES_TAG_S)
      hdr_last = hdr_start;
    else if (t1 == bsdes_pkg::BSDES_TAG_L)
      hdr_last = hdr_start + 3'h1;
    else
      hdr_last = hdr_start + 3'h2;
  end

  // Frame and cipher control
  bsdes_state_e st_reg;
  logic pend_reg;
  logic frame_reg;
  logic enc_reg;
  logic [2:0] start_idx_reg;
  logic [2:0] last_idx_reg;
  logic [2:0] pass_idx_reg;
  logic [63:0] chain_reg;
  logic [63:0] ct_reg;
  logic ciph_start_reg;
  logic ciph_done;
  logic [63:0] ciph_block;
  logic [63:0] ciph_in;
  logic [63:0] plain_next;
  logic ciph_enc;
  logic hdr_ok;
  logic take;
  logic err_set;

  assign ciph_in = (pass_idx_reg == last_idx_reg) ? ct_reg : ciph_block;
  assign ciph_enc = tag_of(key_reg[pass_idx_reg]) == bsdes_pkg::BSDES_TAG_M;
  assign plain_next = ciph_block ^ chain_reg;
  assign take = pend_reg && st_reg == ST_IDLE && !key_mode && !clear_evt;
  assign hdr_ok = !o_locked && (!wd_reg.data[bsdes_pkg::BSDES_HDR_ENC_BIT] ||
                  (!wd_reg.data[bsdes_pkg::BSDES_HDR_PART_BIT] && o_keys_loaded &&
                   chain_ok));
  assign err_set = take && ((wd_reg.kind == bsdes_pkg::BSDES_KIND_HDR && !hdr_ok) ||
                   (wd_reg.kind == bsdes_pkg::BSDES_KIND_DATA && !frame_reg));

  bsdes_cipher u_cipher (
    .i_clk(i_mclk),
    .i_rstn(i_rstn),
    .i_start(ciph_start_reg),
    .i_encrypt(ciph_enc),
    .i_key(key_reg[pass_idx_reg].key),
    .i_block(ciph_in),
    .o_done(ciph_done),
    .o_block(ciph_block)
  );

  // Words are acknowledged only once fully handled, which stalls the link
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st_reg <= ST_IDLE;
      pend_reg <= 1'b0;
      wd_reg <= '0;
      ack_reg <= 1'b0;
      frame_reg <= 1'b0;
      enc_reg <= 1'b0;
      start_idx_reg <= 3'h0;
      last_idx_reg <= 3'h0;
      pass_idx_reg <= 3'h0;
      chain_reg <= bsdes_pkg::BSDES_CHAIN_RST;
      ct_reg <= 64'h0;
      ciph_start_reg <= 1'b0;
      o_out_valid <= 1'b0;
      o_out_data <= 64'h0;
      o_locked <= 1'b0;
      o_config_done <= 1'b0;
    end
    else
    begin
      ciph_start_reg <= 1'b0;
      o_out_valid <= 1'b0;
      if (word_evt)
      begin
        wd_reg <= lk_hold_reg;
        pend_reg <= 1'b1;
      end
      if (clear_evt || mode_rise || key_mode)
      begin
        // Frame is abandoned and a word in flight is dropped; memory is wiped only on a clear event or key mode entry
        st_reg <= ST_IDLE;
        frame_reg <= 1'b0;
        if (clear_evt || mode_rise)
        begin
          o_locked <= 1'b0;
          o_config_done <= 1'b0;
        end
        if (pend_reg)
        begin
          pend_reg <= 1'b0;
          ack_reg <= ~ack_reg;
        end
      end
      else
        case (st_reg)
          ST_IDLE:
            if (take)
            begin
              if (wd_reg.kind == bsdes_pkg::BSDES_KIND_DATA && frame_reg && enc_reg)
              begin
                ct_reg <= wd_reg.data;
                pass_idx_reg <= last_idx_reg;
                ciph_start_reg <= 1'b1;
                st_reg <= ST_PASS;
              end
              else
              begin
                pend_reg <= 1'b0;
                ack_reg <= ~ack_reg;
              end
              case (wd_reg.kind)
                bsdes_pkg::BSDES_KIND_HDR:
                  if (hdr_ok)
                  begin
                    frame_reg <= 1'b1;
                    enc_reg <= wd_reg.data[bsdes_pkg::BSDES_HDR_ENC_BIT];
                    start_idx_reg <= hdr_start;
                    last_idx_reg <= hdr_last;
                    o_config_done <= 1'b0;
                  end
                  else
                    frame_reg <= 1'b0;
                bsdes_pkg::BSDES_KIND_SEED:
                  chain_reg <= wd_reg.data;
                bsdes_pkg::BSDES_KIND_DATA:
                  if (frame_reg && !enc_reg)
                  begin
                    o_out_valid <= 1'b1;
                    o_out_data <= wd_reg.data;
                  end
                default:
                  if (frame_reg)
                  begin
                    frame_reg <= 1'b0;
                    o_config_done <= 1'b1;
                    if (enc_reg)
                      o_locked <= 1'b1;
                  end
              endcase
            end
          ST_PASS:
            if (ciph_done)
            begin
              if (pass_idx_reg == start_idx_reg)
              begin
                o_out_valid <= 1'b1;
                o_out_data <= plain_next;
                chain_reg <= ct_reg;
                pend_reg <= 1'b0;
                ack_reg <= ~ack_reg;
                st_reg <= ST_IDLE;
              end
              else
              begin
                pass_idx_reg <= pass_idx_reg - 3'h1;
                ciph_start_reg <= 1'b1;
              end
            end
          default:
            st_reg <= ST_IDLE;
        endcase
    end
  end

  // Error is sticky; a clearing event resets it, as no word is taken in the clearing cycle
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_cfg_error <= 1'b0;
      o_mem_clear <= 1'b0;
      o_key_mode <= 1'b0;
    end
    else
    begin
      if (err_set)
        o_cfg_error <= 1'b1;
      else if (clear_evt || mode_rise)
        o_cfg_error <= 1'b0;
      o_mem_clear <= clear_evt || mode_rise;
      o_key_mode <= key_mode;
    end
  end

  logic last_pass;
  assign last_pass = st_reg == ST_PASS && ciph_done && pass_idx_reg == start_idx_reg &&
                     !clear_evt && !key_mode;

  out_xor_chain_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    last_pass |=> o_out_valid && o_out_data == $past(plain_next))
    else $error("plaintext is not decrypted block xor chain value");
  chain_update_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    last_pass |=> chain_reg == $past(ct_reg))
    else $error("chain value not advanced to current ciphertext");
  plain_bypass_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    take && wd_reg.kind == bsdes_pkg::BSDES_KIND_DATA && frame_reg && !enc_reg
    |=> o_out_valid && o_out_data == $past(wd_reg.data) && st_reg == ST_IDLE)
    else $error("plain word not passed straight through");
  partial_reject_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    take && wd_reg.kind == bsdes_pkg::BSDES_KIND_HDR &&
    wd_reg.data[bsdes_pkg::BSDES_HDR_ENC_BIT] && wd_reg.data[bsdes_pkg::BSDES_HDR_PART_BIT]
    |=> !frame_reg && o_cfg_error)
    else $error("encrypted partial frame accepted");
  lock_after_enc_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    take && wd_reg.kind == bsdes_pkg::BSDES_KIND_END && frame_reg && enc_reg
    |=> o_locked && o_config_done)
    else $error("encrypted frame end did not lock");
  locked_refuse_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    o_locked && take && wd_reg.kind == bsdes_pkg::BSDES_KIND_HDR |=> !frame_reg ##1 o_locked)
    else $error("header accepted while locked");
  key_clear_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    mode_rise |=> !o_keys_loaded && written_reg == '0 && !o_locked)
    else $error("key mode entry did not clear");
  keys_survive_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    clear_evt && !mode_rise && !supply_lost && !wr_rise |=> $stable(key_reg))
    else $error("clearing event disturbed stored keys");
  write_once_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    wr_rise && written_reg[kaddr] && !mode_rise && !supply_lost |=> $stable(key_reg))
    else $error("stored key was rewritten");
  pass_mode_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    ciph_start_reg |-> ciph_enc == (last_idx_reg - start_idx_reg == 3'h2 &&
    pass_idx_reg == start_idx_reg + 3'h1) && pass_idx_reg >= start_idx_reg &&
    pass_idx_reg <= last_idx_reg)
    else $error("pass direction or key index wrong");
  start_key_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    frame_reg && enc_reg |-> start_idx_reg == 3'h0 || start_idx_reg == 3'h3)
    else $error("start key location not zero or three");

  enc_block_c: cover property (@(posedge i_mclk) disable iff (!i_rstn) last_pass);
  plain_word_c: cover property (@(posedge i_mclk) disable iff (!i_rstn)
    o_out_valid && !enc_reg);
  refused_c: cover property (@(posedge i_mclk) disable iff (!i_rstn) err_set && o_locked);
  key_session_c: cover property (@(posedge i_mclk) disable iff (!i_rstn)
    mode_fall && &written_reg);
endmodule

// file: shared/bsdes_pkg.sv
// Constants, tables and carrier types of the bitstream decryptor
package bsdes_pkg;
  localparam int BSDES_BLOCK_W = 64;
  localparam int BSDES_KEY_W = 56;
  localparam int BSDES_HDR_W = 8;
  localparam int BSDES_NUM_KEYS = 6;
  localparam int BSDES_ROUNDS = 16;
  localparam logic [3:0] BSDES_LAST_RND = 4'hf;
  localparam logic [2:0] BSDES_START_LO = 3'h0;
  localparam logic [2:0] BSDES_START_HI = 3'h3;
  // Header word of a frame
  localparam int BSDES_HDR_ENC_BIT = 0;
  localparam int BSDES_HDR_PART_BIT = 1;
  localparam int BSDES_HDR_START_BIT = 2;
  // Sequence tag sits in the low bits of the key header byte
  localparam int BSDES_TAG_LSB = 0;
  typedef enum logic [1:0] {BSDES_TAG_S, BSDES_TAG_F, BSDES_TAG_M, BSDES_TAG_L} bsdes_tag_e;
  typedef enum logic [1:0] {BSDES_KIND_HDR, BSDES_KIND_SEED, BSDES_KIND_DATA,
                            BSDES_KIND_END} bsdes_kind_e;
  typedef struct packed {
    logic [BSDES_HDR_W-1:0] hdr;
    logic [BSDES_KEY_W-1:0] key;
  } bsdes_key_s;
  typedef struct packed {
    bsdes_kind_e kind;
    logic [BSDES_BLOCK_W-1:0] data;
  } bsdes_word_s;
  localparam bsdes_key_s BSDES_KEY_RST = '0;
  localparam logic [63:0] BSDES_CHAIN_RST = 64'h0;
  // Rounds whose key rotation is one place; all others rotate two
  localparam logic [15:0] BSDES_SHIFT1 = 16'h8103;
  localparam int BSDES_IP [64] = '{58,50,42,34,26,18,10,2,60,52,44,36,28,20,12,4,
    62,54,46,38,30,22,14,6,64,56,48,40,32,24,16,8,57,49,41,33,25,17,9,1,
    59,51,43,35,27,19,11,3,61,53,45,37,29,21,13,5,63,55,47,39,31,23,15,7};
  localparam int BSDES_PC1 [56] = '{57,49,41,33,25,17,9,1,58,50,42,34,26,18,
    10,2,59,51,43,35,27,19,11,3,60,52,44,36,63,55,47,39,31,23,15,7,62,54,46,38,
    30,22,14,6,61,53,45,37,29,21,13,5,28,20,12,4};
  localparam int BSDES_PC2 [48] = '{14,17,11,24,1,5,3,28,15,6,21,10,23,19,12,4,
    26,8,16,7,27,20,13,2,41,52,31,37,47,55,30,40,51,45,33,48,44,49,39,56,
    34,53,46,42,50,36,29,32};
  localparam int BSDES_P [32] = '{16,7,20,21,29,12,28,17,1,15,23,26,5,18,31,10,
    2,8,24,14,32,27,3,9,19,13,30,6,22,11,4,25};
  // Eight boxes of four rows, one nibble per entry, first entry leftmost
  localparam logic [2047:0] BSDES_SBOX = {
    256'he4d12fb83a6c59070f74e2d1a6cb953841e8d62bfc973a50fc8249175b3ea06d,
    256'hf18e6b34972dc05a3d47f28ec01a69b50e7ba4d158c6932fd8a13f42b67c05e9,
    256'ha09e63f51dc7b428d70934a6285ecbf1d6498f30b12c5ae71ad069874fe3b52c,
    256'h7de3069a1285bc4fd8b56f03472c1ae9a690cb7df13e52843f06a1d8945bc72e,
    256'h2c417ab6853fd0e9eb2c47d150fa3986421bad78f9c5630eb8c71e2d6f09a453,
    256'hc1af92680d34e75baf427c9561de0b389ef528c3704a1db6432c95fabe17608d,
    256'h4b2ef08d3c975a61d0b7491ae35c2f8614bdc37eaf6805926bd814a7950fe23c,
    256'hd2846fb1a93e50c71fd8a374c56b0e927b419ce206adf35821e74a8dfc90356b};
endpackage

// file: src/bsdes_cipher.sv
// Iterative block cipher core, one round per clock
`timescale 1ns/1ps
module bsdes_cipher (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_start,
  input wire logic i_encrypt,
  input wire logic [55:0] i_key,
  input wire logic [63:0] i_block,
  output logic o_done,
  output logic [63:0] o_block
);
  logic [31:0] l_reg;
  logic [31:0] r_reg;
  logic [55:0] cd_reg;
  logic [3:0] rnd_reg;
  logic busy_reg;
  logic enc_reg;
  logic [63:0] key64;
  logic [63:0] ip_w;
  logic [55:0] pc1_w;
  logic [55:0] cd_use;
  logic [55:0] cd_next;
  logic [47:0] e_w;
  logic [31:0] s_w;
  logic [31:0] f_w;
  logic [63:0] fp_in;
  logic [63:0] fp_w;
  logic one_enc;
  logic one_dec;

  function automatic logic [27:0] rotl(input logic [27:0] x, input logic one);
    rotl = one ? {x[26:0], x[27]} : {x[25:0], x[27:26]};
  endfunction
  function automatic logic [27:0] rotr(input logic [27:0] x, input logic one);
    rotr = one ? {x[0], x[27:1]} : {x[1:0], x[27:2]};
  endfunction

  // Parity bits are not stored, so a zero stands in their place
  always_comb
  begin
    for (int j = 0; j < 8; j++)
      key64[63-8*j -: 8] = {i_key[55-7*j -: 7], 1'b0};
    for (int i = 0; i < 64; i++)
      ip_w[63-i] = i_block[64-bsdes_pkg::BSDES_IP[i]];
    for (int i = 0; i < 56; i++)
      pc1_w[55-i] = key64[64-bsdes_pkg::BSDES_PC1[i]];
  end

  // Decryption walks the key schedule backward from the unrotated key
  always_comb
  begin
    one_enc = bsdes_pkg::BSDES_SHIFT1[rnd_reg];
    one_dec = bsdes_pkg::BSDES_SHIFT1[bsdes_pkg::BSDES_LAST_RND - rnd_reg];
    cd_use = enc_reg ? {rotl(cd_reg[55:28], one_enc), rotl(cd_reg[27:0], one_enc)} : cd_reg;
    cd_next = enc_reg ? cd_use : {rotr(cd_reg[55:28], one_dec), rotr(cd_reg[27:0], one_dec)};
  end

  always_comb
  begin
    logic [5:0] x;
    int n;
    x = 6'h0;
    n = 0;
    for (int g = 0; g < 8; g++)
      for (int j = 0; j < 6; j++)
        e_w[47-6*g-j] = r_reg[31-((4*g+j+31)%32)] ^
                        cd_use[56-bsdes_pkg::BSDES_PC2[6*g+j]];
    for (int b = 0; b < 8; b++)
    begin
      x = e_w[47-6*b -: 6];
      n = b*64 + 32*int'(x[5]) + 16*int'(x[0]) + int'(x[4:1]);
      s_w[31-4*b -: 4] = bsdes_pkg::BSDES_SBOX[2047-4*n -: 4];
    end
    for (int i = 0; i < 32; i++)
      f_w[31-i] = s_w[32-bsdes_pkg::BSDES_P[i]];
    fp_in = {l_reg ^ f_w, r_reg};
    for (int i = 0; i < 64; i++)
      fp_w[64-bsdes_pkg::BSDES_IP[i]] = fp_in[63-i];
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      l_reg <= 32'h0;
      r_reg <= 32'h0;
      cd_reg <= 56'h0;
      rnd_reg <= 4'h0;
      busy_reg <= 1'b0;
      enc_reg <= 1'b0;
    end
    else if (i_start)
    begin
      l_reg <= ip_w[63:32];
      r_reg <= ip_w[31:0];
      cd_reg <= pc1_w;
      rnd_reg <= 4'h0;
      busy_reg <= 1'b1;
      enc_reg <= i_encrypt;
    end
    else if (busy_reg)
    begin
      l_reg <= r_reg;
      r_reg <= l_reg ^ f_w;
      cd_reg <= cd_next;
      rnd_reg <= rnd_reg + 4'h1;
      busy_reg <= (rnd_reg != bsdes_pkg::BSDES_LAST_RND);
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_done <= 1'b0;
      o_block <= 64'h0;
    end
    else
    begin
      o_done <= busy_reg && (rnd_reg == bsdes_pkg::BSDES_LAST_RND);
      if (busy_reg && (rnd_reg == bsdes_pkg::BSDES_LAST_RND))
        o_block <= fp_w;
    end
  end

  cipher_latency_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_start |-> ##17 o_done)
    else $error("cipher pass did not finish in 17 cycles");
endmodule

// file: tb/bsdes_src.sv
// Configuration source model on the link side
`timescale 1ns/1ps
module bsdes_src (
  input wire logic i_lclk,
  input wire logic i_ready,
  output logic o_valid,
  output bsdes_pkg::bsdes_word_s o_word
);
  initial
  begin
    o_valid = 1'h0;
    o_word = '0;
  end
  // One word in flight, held until taken on an edge with ready high
  task automatic send(input logic [1:0] k, input logic [63:0] d);
    int n;
    n = 0;
    @(posedge i_lclk);
    o_valid <= 1'h1;
    o_word <= {k, d};
    do
    begin
      @(posedge i_lclk);
      n++;
    end
    while (i_ready !== 1'h1 && n < 500);
    o_valid <= 1'h0;
    // Scrambled after release so nothing leans on a stale word
    o_word <= ~o_word;
  endtask
endmodule

// file: tb/tb_top.sv
// Bench: plain and encrypted frames, key sessions, clear events
`timescale 1ns/1ps
module tb_top;
  logic i_mclk = 1'h0, i_lclk = 1'h0, i_rstn = 1'h0, i_cfg_valid, o_cfg_ready;
  bsdes_pkg::bsdes_word_s i_cfg_word;
  logic i_scan_key_mode = 1'h0, i_scan_key_wr = 1'h0;
  logic [2:0] i_scan_key_addr = 3'h0;
  bsdes_pkg::bsdes_key_s i_scan_key_data = '0;
  logic i_config_clear_pin_n = 1'h1, i_scan_startup_instruction = 1'h0;
  logic i_core_power_good = 1'h1, i_key_backup_supply = 1'h1, i_auxiliary_supply = 1'h1;
  logic o_out_valid, o_keys_loaded, o_key_mode, o_locked, o_cfg_error;
  logic o_config_done, o_mem_clear;
  logic [63:0] o_out_data, last;
  int errors = 0, compares = 0, cyc = 0, outs = 0, clrs = 0;
  bsdes_decryptor i_dut (.i_mclk, .i_rstn, .i_lclk, .i_cfg_valid, .i_cfg_word, .o_cfg_ready,
    .i_scan_key_mode, .i_scan_key_wr, .i_scan_key_addr, .i_scan_key_data,
    .i_config_clear_pin_n, .i_scan_startup_instruction, .i_core_power_good,
    .i_key_backup_supply, .i_auxiliary_supply, .o_out_valid, .o_out_data, .o_keys_loaded,
    .o_key_mode, .o_locked, .o_cfg_error, .o_config_done, .o_mem_clear);
  bsdes_src i_src (.i_lclk, .i_ready(o_cfg_ready), .o_valid(i_cfg_valid), .o_word(i_cfg_word));
  initial
  forever #2.5 i_mclk = ~i_mclk;
  // Odd start offset keeps the link clock out of step with the core
  initial
  begin
    #3.7;
    forever #6 i_lclk = ~i_lclk;
  end
  task automatic results();
    if (errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  always @(posedge i_mclk)
  begin
    cyc <= cyc + 1;
    if (o_out_valid === 1'h1)
    begin
      outs <= outs + 1;
      last <= o_out_data;
    end
    if (o_mem_clear === 1'h1)
      clrs <= clrs + 1;
    if (cyc == 30000)
    begin
      errors++;
      results();
    end
  end
  task automatic idle();
    int n;
    n = 0;
    repeat (4) @(posedge i_lclk);
    while (o_cfg_ready !== 1'h1 && n < 500)
    begin
      @(posedge i_mclk);
      n++;
    end
    repeat (8) @(posedge i_mclk);
  endtask
  // Clear events: 0 pin, 1 startup instruction, 2 power cycle
  task automatic evt(input int w);
    i_config_clear_pin_n <= (w != 0);
    i_scan_startup_instruction <= (w == 1);
    i_core_power_good <= (w != 2);
    repeat (4) @(posedge i_mclk);
    {i_config_clear_pin_n, i_scan_startup_instruction, i_core_power_good} <= 3'h5;
    repeat (8) @(posedge i_mclk);
  endtask
  task automatic keys(input int n, input int same = 0);
    int c;
    c = clrs;
    i_scan_key_mode <= 1'h1;
    repeat (6) @(posedge i_mclk);
    chk(o_key_mode, 64'h1);
    chk(clrs - c, 64'h1);
    // An extra write to a used location must be ignored
    for (int i = 0; i < n + same; i++)
    begin
      i_scan_key_addr <= 3'(i % 6);
      i_scan_key_data <= {6'h0, 2'(same ? (i < 3 ? i + 1 : 0) : i % 3 + 1),
                          56'h0123456789abcd + 56'(same ? i / 6 : i)};
      repeat (4) @(posedge i_mclk);
      i_scan_key_wr <= 1'h1;
      repeat (4) @(posedge i_mclk);
      i_scan_key_wr <= 1'h0;
      repeat (4) @(posedge i_mclk);
    end
    i_scan_key_mode <= 1'h0;
    repeat (6) @(posedge i_mclk);
    chk(o_keys_loaded, 64'(n == 6));
  endtask
  task automatic plain_frame();
    i_src.send(2'h0, 64'h0);
    i_src.send(2'h2, 64'h0123456789abcdef);
    idle();
    chk(last, 64'h0123456789abcdef);
    i_src.send(2'h3, 64'h0);
    idle();
    chk(o_config_done, 64'h1);
    chk(o_locked, 64'h0);
  endtask
  task automatic enc_frame();
    int o, c;
    i_src.send(2'h0, 64'h3);
    idle();
    chk(o_cfg_error, 64'h1);
    evt(0);
    chk(o_cfg_error, 64'h0);
    o = outs;
    i_src.send(2'h0, 64'h5);
    i_src.send(2'h1, 64'h503f2f655b1b2f82);
    i_src.send(2'h2, 64'h1122334455667788);
    i_src.send(2'h2, 64'h99aabbccddeeff00);
    i_src.send(2'h3, 64'h0);
    idle();
    chk(outs - o, 64'h2);
    chk(o_locked, 64'h1);
    i_src.send(2'h0, 64'h0);
    idle();
    chk(o_cfg_error, 64'h1);
    c = clrs;
    evt(2);
    chk({o_locked, o_keys_loaded}, 64'h1);
    chk(clrs - c, 64'h1);
  endtask
  // Equal keys: triple from zero must match single at three; seed shows in block one only
  task automatic cbc_pair();
    logic [63:0] p1, p2;
    i_src.send(2'h0, 64'h1);
    i_src.send(2'h1, 64'h503f2f655b1b2f82);
    i_src.send(2'h2, 64'h1122334455667788);
    idle();
    p1 = last;
    i_src.send(2'h2, 64'h99aabbccddeeff00);
    idle();
    p2 = last;
    i_src.send(2'h3, 64'h0);
    idle();
    evt(1);
    i_src.send(2'h0, 64'h5);
    i_src.send(2'h1, 64'h503f2f655b1b2f82 ^ 64'hff);
    i_src.send(2'h2, 64'h1122334455667788);
    idle();
    chk(last, p1 ^ 64'hff);
    i_src.send(2'h2, 64'h99aabbccddeeff00);
    idle();
    chk(last, p2);
    i_src.send(2'h3, 64'h0);
    idle();
    chk(o_locked, 64'h1);
  endtask
  initial
  begin
    repeat (16) @(posedge i_mclk);
    i_rstn <= 1'h1;
    repeat (6) @(posedge i_mclk);
    chk({o_cfg_ready, o_keys_loaded, o_locked}, 64'h4);
    plain_frame();
    i_src.send(2'h0, 64'h1);
    idle();
    chk(o_cfg_error, 64'h1);
    evt(1);
    chk(o_cfg_error, 64'h0);
    keys(5);
    keys(6);
    enc_frame();
    {i_key_backup_supply, i_auxiliary_supply} <= 2'h0;
    repeat (8) @(posedge i_mclk);
    chk(o_keys_loaded, 64'h0);
    {i_key_backup_supply, i_auxiliary_supply} <= 2'h3;
    keys(6, 1);
    cbc_pair();
    results();
  end
endmodule
